// ---- e1ec_defines.vh ----
`ifndef E1EC_DEFINES_VH
`define E1EC_DEFINES_VH

// ==========================================================
// register offsets on the parallel port
`define E1EC_ADDR_VIOL_HIGH 8'h00
`define E1EC_ADDR_VIOL_LOW 8'h01
`define E1EC_ADDR_CRC_FAS_UPPER 8'h02
`define E1EC_ADDR_CRC_LOW 8'h03
`define E1EC_ADDR_EBIT_FAS_MID 8'h04
`define E1EC_ADDR_EBIT_LOW 8'h05
`define E1EC_UNMAPPED_DATA 8'h00

// ==========================================================
// counter widths and field positions
`define E1EC_VIOL_WIDTH 16
`define E1EC_CRC_WIDTH 10
`define E1EC_EBIT_WIDTH 10
`define E1EC_FAS_WIDTH 12
`define E1EC_VIOL_MAX 16'hffff
`define E1EC_FAS_SPLIT 6
`define E1EC_COUNT_RESET 16'h0000
`define E1EC_CRC_RESET 10'h000
`define E1EC_EBIT_RESET 10'h000
`define E1EC_FAS_RESET 12'h000
`define E1EC_STATUS_RESET 1'b0

// ==========================================================
// e-bit position in the crc4 multiframe
`define E1EC_EBIT_FRAME_A 4'hd
`define E1EC_EBIT_FRAME_B 4'hf

// ==========================================================
// interval timing at the 25 mhz master clock
`define E1EC_CLK_HZ 25000000
`define E1EC_LONG_INTERVAL_MS 1000
`define E1EC_SHORT_INTERVAL_US 62500
`define E1EC_LONG_CYCLES ((`E1EC_CLK_HZ / 1000) * `E1EC_LONG_INTERVAL_MS)
`define E1EC_SHORT_CYCLES ((`E1EC_CLK_HZ / 1000000) * `E1EC_SHORT_INTERVAL_US)
`define E1EC_TIMER_WIDTH 25

`endif

// ---- e1ec_error_counters.v ----
// Notes on behaviour
// - refresh all counts every second, or every 62.5 ms when rate select is set.
// - latched counts stay unchanged and readable for the whole next interval.
// - interval timer status bit sets at every update boundary.
// - interval timer interrupt appears only while its mask bit is one.
// - violation count is 16 bits, high byte at 0x00, low byte at 0x01.
// - type select zero counts bipolar violations, two same-polarity marks in a row.
// - with hdb3 decoding on, substitution-word violations are not counted as bipolar.
// - type select one counts code violations, successive same-polarity bipolar violations.
// - violation counter counts in every state, sync loss included.
// - violation counter saturates at 65535 within an interval, never wraps.
// - crc4 errors in 10 bits, msb at 0x02 bit 1, lsb at 0x03 bit 0.
// - crc4 and e-bit counts hold on frame or crc4 sync loss, not cas.
// - e-bit count increments for each zero e bit of frames 13 and 15.
// - e-bit count msb at 0x04 bit 1, lsb at 0x05 bit 0.
// - frame alignment word errors in 12 bits, halted while receive sync is lost.
// - framing count upper six bits at 0x02 [7:2], lower six at 0x04 [7:2].
// - crc4, e-bit and framing counters need no saturation, limits never reached.
`timescale 1ns/10ps
`include "e1ec_defines.vh"

module e1ec_error_counters #(
   parameter LONG_CYCLES = `E1EC_LONG_CYCLES,
   parameter SHORT_CYCLES = `E1EC_SHORT_CYCLES
) (
   // clock and reset
   input wire mclk_i,
   input wire resetn_i,

   // control bits from the common control registers
   input wire update_rate_select_i,
   input wire violation_type_select_i,
   input wire receive_hdb3_enable_i,
   input wire interval_timer_int_mask_i,
   input wire interval_timer_status_clear_i,

   // received line symbols
   input wire bit_strobe_i,
   input wire mark_pos_i,
   input wire mark_neg_i,

   // framer error events and sync state
   input wire crc_error_i,
   input wire fas_error_i,
   input wire ts0_first_bit_strobe_i,
   input wire ts0_first_bit_i,
   input wire [3:0] frame_number_i,
   input wire crc4_mode_i,
   input wire frame_sync_loss_i,
   input wire crc4_mf_sync_loss_i,
   input wire cas_mf_sync_loss_i,
   input wire receive_sync_loss_flag_i,

   // parallel port read side
   input wire rd_i,
   input wire [7:0] addr_i,
   output reg [7:0] rd_data_o,

   // timer status and interrupt
   output reg interval_timer_status_o,
   output wire interval_timer_int_o
);

   // ==========================================================
   // shared increment with optional ceiling
   function [15:0] e1ec_next_count;
      input [15:0] cur;
      input inc;
      input restart;
      input [15:0] ceiling;
      reg [15:0] base;
      begin
         base = restart ? `E1EC_COUNT_RESET : cur;
         if (inc && (base != ceiling)) begin
            e1ec_next_count = base + 16'h0001;
         end else begin
            e1ec_next_count = base;
         end
      end
   endfunction

   // ==========================================================
   // boundary timer and violation detector
   wire boundary;
   wire violation;

   e1ec_interval_timer #(
      .LONG_CYCLES(LONG_CYCLES),
      .SHORT_CYCLES(SHORT_CYCLES),
      .CNT_W(`E1EC_TIMER_WIDTH)
   ) u_timer (
      .mclk_i(mclk_i),
      .resetn_i(resetn_i),
      .rate_select_i(update_rate_select_i),
      .tick_o(boundary)
   );

   e1ec_violation_detect u_viol (
      .mclk_i(mclk_i),
      .resetn_i(resetn_i),
      .violation_type_select_i(violation_type_select_i),
      .receive_hdb3_enable_i(receive_hdb3_enable_i),
      .bit_strobe_i(bit_strobe_i),
      .mark_pos_i(mark_pos_i),
      .mark_neg_i(mark_neg_i),
      .violation_o(violation)
   );

   // ==========================================================
   // count qualifiers
   // cas multiframe loss is deliberately not part of this hold
   wire crc_ebit_hold = frame_sync_loss_i | crc4_mf_sync_loss_i;
   wire cas_loss_ignored = cas_mf_sync_loss_i & 1'b0;
   wire crc_inc = crc_error_i & ~crc_ebit_hold & ~cas_loss_ignored;
   wire ebit_pos = (frame_number_i == `E1EC_EBIT_FRAME_A) |
                   (frame_number_i == `E1EC_EBIT_FRAME_B);
   wire ebit_inc = ts0_first_bit_strobe_i & ebit_pos & ~ts0_first_bit_i &
                   crc4_mode_i & ~crc_ebit_hold;
   wire fas_inc = fas_error_i & ~receive_sync_loss_flag_i;
   wire viol_inc = violation;

   // ==========================================================
   // running counts for the current interval
   reg [`E1EC_VIOL_WIDTH-1:0] viol_run;
   reg [`E1EC_CRC_WIDTH-1:0] crc_run;
   reg [`E1EC_EBIT_WIDTH-1:0] ebit_run;
   reg [`E1EC_FAS_WIDTH-1:0] fas_run;

   wire [15:0] next_viol_run;
   wire [15:0] next_crc_run;
   wire [15:0] next_ebit_run;
   wire [15:0] next_fas_run;

   // an event in the boundary cycle belongs to the new interval
   assign next_viol_run = e1ec_next_count(viol_run, viol_inc, boundary,
                                          `E1EC_VIOL_MAX);
   assign next_crc_run = e1ec_next_count({6'h00, crc_run}, crc_inc, boundary,
                                         16'hffff);
   assign next_ebit_run = e1ec_next_count({6'h00, ebit_run}, ebit_inc, boundary,
                                          16'hffff);
   assign next_fas_run = e1ec_next_count({4'h0, fas_run}, fas_inc, boundary,
                                         16'hffff);

   // running counters
   always @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         viol_run <= `E1EC_COUNT_RESET;
         crc_run <= `E1EC_CRC_RESET;
         ebit_run <= `E1EC_EBIT_RESET;
         fas_run <= `E1EC_FAS_RESET;
      end else begin
         viol_run <= next_viol_run;
         crc_run <= next_crc_run[`E1EC_CRC_WIDTH-1:0];
         ebit_run <= next_ebit_run[`E1EC_EBIT_WIDTH-1:0];
         fas_run <= next_fas_run[`E1EC_FAS_WIDTH-1:0];
      end
   end

   // ==========================================================
   // latched counts seen by the host
   reg [`E1EC_VIOL_WIDTH-1:0] viol_held;
   reg [`E1EC_CRC_WIDTH-1:0] crc_held;
   reg [`E1EC_EBIT_WIDTH-1:0] ebit_held;
   reg [`E1EC_FAS_WIDTH-1:0] fas_held;

   // only the boundary writes these, so a slow host sees a stable snapshot
   always @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         viol_held <= `E1EC_COUNT_RESET;
         crc_held <= `E1EC_CRC_RESET;
         ebit_held <= `E1EC_EBIT_RESET;
         fas_held <= `E1EC_FAS_RESET;
      end else if (boundary) begin
         viol_held <= viol_run;
         crc_held <= crc_run;
         ebit_held <= ebit_run;
         fas_held <= fas_run;
      end
   end

   // ==========================================================
   // interval timer status and interrupt
   // a boundary in the clear cycle wins so no interval goes unannounced
   always @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         interval_timer_status_o <= `E1EC_STATUS_RESET;
      end else if (boundary) begin
         interval_timer_status_o <= 1'b1;
      end else if (interval_timer_status_clear_i) begin
         interval_timer_status_o <= 1'b0;
      end
   end

   assign interval_timer_int_o = interval_timer_status_o &
                                 interval_timer_int_mask_i;

   // ==========================================================
   // register byte lanes
   wire [7:0] byte_viol_high = viol_held[15:8];
   wire [7:0] byte_viol_low = viol_held[7:0];
   wire [7:0] byte_crc_fas_upper = {fas_held[`E1EC_FAS_WIDTH-1:`E1EC_FAS_SPLIT],
                                    crc_held[9:8]};
   wire [7:0] byte_crc_low = crc_held[7:0];
   wire [7:0] byte_ebit_fas_mid = {fas_held[`E1EC_FAS_SPLIT-1:0],
                                   ebit_held[9:8]};
   wire [7:0] byte_ebit_low = ebit_held[7:0];

   // read data registered one cycle after the strobe; unmapped reads give zero
   always @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rd_data_o <= `E1EC_UNMAPPED_DATA;
      end else if (rd_i) begin
         case (addr_i)
            `E1EC_ADDR_VIOL_HIGH: begin
               rd_data_o <= byte_viol_high;
            end
            `E1EC_ADDR_VIOL_LOW: begin
               rd_data_o <= byte_viol_low;
            end
            `E1EC_ADDR_CRC_FAS_UPPER: begin
               rd_data_o <= byte_crc_fas_upper;
            end
            `E1EC_ADDR_CRC_LOW: begin
               rd_data_o <= byte_crc_low;
            end
            `E1EC_ADDR_EBIT_FAS_MID: begin
               rd_data_o <= byte_ebit_fas_mid;
            end
            `E1EC_ADDR_EBIT_LOW: begin
               rd_data_o <= byte_ebit_low;
            end
            default: begin
               rd_data_o <= `E1EC_UNMAPPED_DATA;
            end
         endcase
      end
   end

endmodule // e1ec_error_counters

// ---- e1ec_error_counters_asserts.sv ----
`timescale 1ns/10ps
// ==========================================================
// port checker of the error counter block
module e1ec_chk #(
   parameter LONG_CYCLES = 64
) (
   // clock and reset
   input wire mclk_i,
   input wire resetn_i,
   // watched ports
   input wire update_rate_select_i,
   input wire interval_timer_int_mask_i,
   input wire interval_timer_status_clear_i,
   input wire rd_i,
   input wire [7:0] addr_i,
   input wire [7:0] rd_data_o,
   input wire interval_timer_status_o,
   input wire interval_timer_int_o
);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!resetn_i);
   int low_cnt;
   // wait since the status was last high; a rate change restarts the interval
   always @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i)
         low_cnt <= 0;
      else if (interval_timer_status_o || $changed(update_rate_select_i))
         low_cnt <= 0;
      else
         low_cnt <= low_cnt + 1;
   end
   // ==========================================================
   // timer status and interrupt
   property p_int_gate; interval_timer_int_o == (interval_timer_status_o && interval_timer_int_mask_i); endproperty
   a_int_gate: assert property (p_int_gate) else $error("interrupt differs from status and mask");
   property p_int_at_set; $rose(interval_timer_status_o) |-> interval_timer_int_o == interval_timer_int_mask_i; endproperty
   a_int_at_set: assert property (p_int_at_set) else $error("interrupt wrong at boundary");
   property p_masked; !interval_timer_int_mask_i |-> !interval_timer_int_o; endproperty
   a_masked: assert property (p_masked) else $error("masked interrupt raised");
   property p_status_hold; interval_timer_status_o && !interval_timer_status_clear_i |=> interval_timer_status_o; endproperty
   a_status_hold: assert property (p_status_hold) else $error("status dropped without clear");
   property p_status_fall; $fell(interval_timer_status_o) |-> $past(interval_timer_status_clear_i); endproperty
   a_status_fall: assert property (p_status_fall) else $error("status fell with no clear");
   property p_status_due; low_cnt <= LONG_CYCLES + 4; endproperty
   a_status_due: assert property (p_status_due) else $error("boundary overdue");
   property p_rate_restart; $changed(update_rate_select_i) |-> ##3 (!$rose(interval_timer_status_o))[*8]; endproperty
   a_rate_restart: assert property (p_rate_restart) else $error("boundary right after rate change");
   // ==========================================================
   // read port and cover points
   property p_rd_hold; !rd_i |=> $stable(rd_data_o); endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("read data moved without a read");
   property p_unmapped; rd_i && addr_i > 8'h05 |=> rd_data_o == 8'h00; endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   c_boundary: cover property ($rose(interval_timer_status_o));
   c_read: cover property (rd_i && addr_i == 8'h00);
   c_rate: cover property ($changed(update_rate_select_i));
endmodule // e1ec_chk

bind e1ec_error_counters e1ec_chk #(.LONG_CYCLES(LONG_CYCLES)) i_chk (.mclk_i(mclk_i), .resetn_i(resetn_i),
   .update_rate_select_i(update_rate_select_i), .interval_timer_int_mask_i(interval_timer_int_mask_i),
   .interval_timer_status_clear_i(interval_timer_status_clear_i), .rd_i(rd_i), .addr_i(addr_i),
   .rd_data_o(rd_data_o), .interval_timer_status_o(interval_timer_status_o),
   .interval_timer_int_o(interval_timer_int_o));

// ---- e1ec_host_model.sv ----
`timescale 1ns/10ps
// ==========================================================
// host processor on the parallel read port
module e1ec_host_model (
   // clock
   input wire mclk_i,
   // read port
   output logic rd_o,
   output logic [7:0] addr_o,
   input wire [7:0] rd_data_i
);
   initial begin
      rd_o = 1'b0;
      addr_o = 8'h5a;
   end
   // one read, optionally after idle cycles; idle address is scrambled so stale values never help
   task automatic rd(input logic [7:0] a, input int idle, output logic [7:0] d);
      repeat (idle) @(negedge mclk_i);
      @(negedge mclk_i);
      rd_o = 1'b1;
      addr_o = a;
      @(negedge mclk_i);
      d = rd_data_i;
      rd_o = 1'b0;
      addr_o = ~a;
   endtask
endmodule // e1ec_host_model

// ---- e1ec_interval_timer.v ----
`timescale 1ns/10ps
`include "e1ec_defines.vh"

// ==========================================================
// interval timer: one-cycle tick at each update boundary
module e1ec_interval_timer #(
   parameter LONG_CYCLES = `E1EC_LONG_CYCLES,
   parameter SHORT_CYCLES = `E1EC_SHORT_CYCLES,
   parameter CNT_W = `E1EC_TIMER_WIDTH
) (
   // clock and reset
   input wire mclk_i,
   input wire resetn_i,
   // control
   input wire rate_select_i,
   // boundary
   output reg tick_o
);

   // full-width terminal counts, cut to the counter width on purpose
   localparam integer LONG_LAST_FULL = LONG_CYCLES - 1;
   localparam integer SHORT_LAST_FULL = SHORT_CYCLES - 1;
   localparam [CNT_W-1:0] LONG_LAST = LONG_LAST_FULL[CNT_W-1:0];
   localparam [CNT_W-1:0] SHORT_LAST = SHORT_LAST_FULL[CNT_W-1:0];

   reg [CNT_W-1:0] cnt;
   reg rate_seen;
   wire [CNT_W-1:0] last = rate_select_i ? SHORT_LAST : LONG_LAST;

   // a rate change restarts the interval so no half-length interval mixes rates
   always @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         cnt <= {CNT_W{1'b0}};
         rate_seen <= 1'b0;
         tick_o <= 1'b0;
      end else begin
         rate_seen <= rate_select_i;
         tick_o <= 1'b0;
         if (rate_seen != rate_select_i) begin
            cnt <= {CNT_W{1'b0}};
         end else if (cnt >= last) begin
            cnt <= {CNT_W{1'b0}};
            tick_o <= 1'b1;
         end else begin
            cnt <= cnt + {{(CNT_W-1){1'b0}}, 1'b1};
         end
      end
   end

endmodule // e1ec_interval_timer

// ---- e1ec_violation_detect.v ----
`timescale 1ns/10ps
`include "e1ec_defines.vh"

// ==========================================================
// line violation detector: bipolar or code violations
module e1ec_violation_detect (
   // clock and reset
   input wire mclk_i,
   input wire resetn_i,
   // control
   input wire violation_type_select_i,
   input wire receive_hdb3_enable_i,
   // received symbols
   input wire bit_strobe_i,
   input wire mark_pos_i,
   input wire mark_neg_i,
   // result
   output reg violation_o
);

   reg have_mark;
   reg last_pol;
   reg have_bpv;
   reg last_bpv_pol;
   reg [1:0] zero_run;

   wire is_mark = mark_pos_i | mark_neg_i;
   wire pol = mark_pos_i;
   wire bipolar_violation = bit_strobe_i & is_mark & have_mark & (pol == last_pol);
   // a violation after two zeros closes a 000v or b00v substitution
   wire hdb3_word = receive_hdb3_enable_i & (zero_run == 2'd2);
   wire cv = bipolar_violation & have_bpv & (pol == last_bpv_pol);

   // symbol history and one-cycle violation pulse
   always @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         have_mark <= 1'b0;
         last_pol <= 1'b0;
         have_bpv <= 1'b0;
         last_bpv_pol <= 1'b0;
         zero_run <= 2'd0;
         violation_o <= 1'b0;
      end else begin
         violation_o <= 1'b0;
         if (bit_strobe_i) begin
            if (is_mark) begin
               have_mark <= 1'b1;
               last_pol <= pol;
               zero_run <= 2'd0;
            end else if (zero_run != 2'd2) begin
               zero_run <= zero_run + 2'd1;
            end
            if (bipolar_violation) begin
               have_bpv <= 1'b1;
               last_bpv_pol <= pol;
            end
            if (violation_type_select_i) begin
               violation_o <= cv;
            end else begin
               violation_o <= bipolar_violation & ~hdb3_word;
            end
         end
      end
   end

endmodule // e1ec_violation_detect

// ---- tb_top.sv ----
`timescale 1ns/10ps
// ==========================================================
// bench of the error counter block
module tb_top;
   localparam int LONG_C = 66000;
   localparam int SHORT_C = 400;
   logic mclk_i, resetn_i, rate, vtype, hdb3, mask, sclr, bstb, mpos, mneg;
   logic crc, fas, tstb, tbit, crc4m, fsl, msl, casl, receive_sync_loss_flag, pv, last, bv, bp;
   logic [3:0] frame;
   logic [7:0] d;
   logic [15:0] ev, hv;
   logic [9:0] ec, ee, hc, he;
   logic [11:0] ef, hf;
   logic [31:0] r = 32'h9492;
   int n_errors = 0;
   int checks_done = 0;
   int cyc = 0;
   int t0, t1, t2, zr;
   wire rd, status, intr;
   wire [7:0] addr, rdata;

   e1ec_error_counters #(.LONG_CYCLES(LONG_C), .SHORT_CYCLES(SHORT_C)) i_dut (
      .mclk_i(mclk_i), .resetn_i(resetn_i), .update_rate_select_i(rate), .violation_type_select_i(vtype),
      .receive_hdb3_enable_i(hdb3), .interval_timer_int_mask_i(mask), .interval_timer_status_clear_i(sclr),
      .bit_strobe_i(bstb), .mark_pos_i(mpos), .mark_neg_i(mneg), .crc_error_i(crc), .fas_error_i(fas),
      .ts0_first_bit_strobe_i(tstb), .ts0_first_bit_i(tbit), .frame_number_i(frame), .crc4_mode_i(crc4m),
      .frame_sync_loss_i(fsl), .crc4_mf_sync_loss_i(msl), .cas_mf_sync_loss_i(casl),
      .receive_sync_loss_flag_i(receive_sync_loss_flag), .rd_i(rd), .addr_i(addr), .rd_data_o(rdata),
      .interval_timer_status_o(status), .interval_timer_int_o(intr));
   e1ec_host_model i_host (.mclk_i(mclk_i), .rd_o(rd), .addr_o(addr), .rd_data_i(rdata));

   // 25 mhz clock and a free cycle count for period checks
   initial begin
      mclk_i = 1'b0;
      forever #20 mclk_i = ~mclk_i;
   end
   always @(posedge mclk_i) cyc <= cyc + 1;

   // ==========================================================
   // expectation helpers
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], 1'b0} ^ (x[31] ? 32'h04c11db7 : 32'h0);
   endfunction
   function automatic logic [7:0] pack(input logic [7:0] a, input logic [15:0] v, input logic [9:0] c, e,
                                       input logic [11:0] f);
      case (a)
         8'h00: return v[15:8];
         8'h01: return v[7:0];
         8'h02: return {f[11:6], c[9:8]};
         8'h03: return c[7:0];
         8'h04: return {f[5:0], e[9:8]};
         8'h05: return e[7:0];
         default: return 8'h00;
      endcase
   endfunction
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic summarize;
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // ==========================================================
   // bus and stimulus tasks
   // all six offsets plus one unmapped address, prompt and slow reads mixed
   task automatic read_all(input logic [15:0] v, input logic [9:0] c, e, input logic [11:0] f);
      for (int a = 0; a < 7; a++) begin
         i_host.rd(a == 6 ? {1'b1, r[6:0]} : 8'(a), a % 2, d);
         chk("read data", pack(a == 6 ? 8'h80 : 8'(a), v, c, e, f), d);
      end
   endtask
   // bounded wait for a boundary
   task automatic wait_set(input int lim);
      int i;
      for (i = 0; i < lim && status !== 1'b1; i++)
         @(negedge mclk_i);
      if (i == lim) begin
         n_errors++;
         $display("ERROR status wait expected 1 seen %b", status);
         summarize();
      end else begin
         t0 = t1;
         t1 = cyc;
         chk("interrupt", {7'h0, mask}, {7'h0, intr});
      end
   endtask
   // random line symbols and framer events, counted as the block should
   task automatic inject(input int n);
      repeat (n) begin
         @(negedge mclk_i);
         r = lfsr(r);
         {crc, fas, tstb, tbit, frame, fsl, msl, casl, receive_sync_loss_flag} = {r[3:0], r[7:4], &r[10:8], &r[13:11], r[14], &r[16:15]};
         {bstb, mpos, mneg} = {r[17] | r[18], r[20:19] == 2'd1, r[20:19] == 2'd2};
         if (crc && !fsl && !msl) ec++;
         if (fas && !receive_sync_loss_flag) ef++;
         if (tstb && !tbit && crc4m && (frame == 4'hd || frame == 4'hf) && !fsl && !msl) ee++;
         if (bstb && (mpos || mneg)) begin
            if (pv && last == mpos) begin
               if (vtype ? (bv && bp == mpos) : !(hdb3 && zr >= 2)) ev++;
               bv = 1'b1;
               bp = mpos;
            end
            pv = 1'b1;
            last = mpos;
            zr = 0;
         end else if (bstb)
            zr++;
      end
      // pulses last one edge only; held levels would keep counting while the bench idles
      @(negedge mclk_i);
      {crc, fas, tstb, bstb} = 4'h0;
   endtask

   // ==========================================================
   // main sequence
   initial begin
      {rate, vtype, hdb3, mask, sclr, bstb, mpos, mneg, crc, fas, tstb, tbit, crc4m, fsl, msl, casl, receive_sync_loss_flag} = 17'h10000;
      frame = 4'h0;
      resetn_i = 1'b0;
      {ev, ec, ee, ef, pv, last, bv, bp} = '0;
      zr = 0;
      repeat (12) @(posedge mclk_i);
      @(negedge mclk_i);
      resetn_i = 1'b1;
      read_all(16'h0, 10'h0, 10'h0, 12'h0);
      inject(40);
      // four short intervals over three counting modes, read before and after new traffic from the second on
      for (int m = 0; m < 4; m++) begin
         wait_set(SHORT_C + 8);
         if (m > 1) chk("short period", 8'h00, 8'(t1 - t0 - SHORT_C));
         {hv, hc, he, hf} = {ev, ec, ee, ef};
         {ev, ec, ee, ef} = '0;
         mask = r[5];
         if (m > 0) read_all(hv, hc, he, hf);
         chk("status held", 8'h01, {7'h0, status});
         sclr = 1'b1;
         @(negedge mclk_i);
         sclr = 1'b0;
         chk("status cleared", 8'h00, {7'h0, status});
         {vtype, hdb3, crc4m} = (m == 1) ? 3'b010 : (m == 2) ? 3'b111 : 3'b001;
         inject(300);
         if (m > 0) read_all(hv, hc, he, hf);
      end
      // long interval under sync loss: a same-polarity stream must saturate, not wrap
      {crc, fas, tstb, rate, vtype, hdb3, bstb, mpos, mneg, receive_sync_loss_flag} = 10'b0000001101;
      t2 = cyc;
      repeat (LONG_C - 200) @(negedge mclk_i);
      bstb = 1'b0;
      wait_set(400);
      chk("long period", 8'h01, {7'h0, (t1 - t2 >= LONG_C) && (t1 - t2 <= LONG_C + 4)});
      i_host.rd(8'h00, 0, d);
      chk("violation high", 8'hff, d);
      i_host.rd(8'h01, 1, d);
      chk("violation low", 8'hff, d);
      summarize();
   end
endmodule // tb_top
